// [core/ssbr_defs.vh]
// register map, field positions and reset values of the serial status block
`ifndef SSBR_DEFS_VH
`define SSBR_DEFS_VH
`define SSBR_OFS_FLAGS      8'h00
`define SSBR_OFS_DIVISOR    8'h04
`define SSBR_OFS_TXBUF      8'h08
`define SSBR_OFS_RXBUF      8'h0C
`define SSBR_OFS_CONTROL    8'h10
`define SSBR_OFS_MODE       8'h14
`define SSBR_OFS_IRQSTAT    8'h18
`define SSBR_OFS_IRQMASK    8'h1C
`define SSBR_TX_BUFFER_EMPTY_BIT       7
`define SSBR_RX_BUFFER_FULL_BIT       6
`define SSBR_OVR_BIT        5
`define SSBR_FRM_BIT        4
`define SSBR_PAR_BIT        3
`define SSBR_TRANSMIT_END_FLAG_BIT       2
`define SSBR_RX_ADDR_FLAG_BIT_BIT       1
`define SSBR_TX_ADDR_FLAG_BIT_BIT       0
`define SSBR_FLAGS_RESET    8'h84
`define SSBR_DIVISOR_RESET  8'hFF
`define SSBR_TXON_BIT       5
`define SSBR_RXON_BIT       4
`define SSBR_WAIT_BIT       3
`define SSBR_SYNC_BIT       7
`define SSBR_ASYNC_BASE     20'h00020
`define SSBR_SYNC_BASE      20'h00004
`define SSBR_IRQ_TXE_BIT    0
`define SSBR_IRQ_RXF_BIT    1
`define SSBR_IRQ_ERR_BIT    2
`define SSBR_IRQ_TRANSMIT_END_FLAG_BIT   3
`endif

// [core/ssbr_core.v]
// status flags, bit-rate divisor and bit-rate generator of the serial unit
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "ssbr_defs.vh"
// Summary of operation
// R1 - error and buffer flags: software may only clear
// R2 - tx empty resets one, set disabled/transfer
// R3 - tx empty cleared by armed zero, data write
// R4 - rx full resets zero, set on clean receive
// R5 - rx full cleared by armed zero, buffer read
// R6 - overrun resets zero, cleared by armed zero
// R7 - framing error resets zero, armed zero clears
// R8 - parity error resets zero, armed zero clears
// R9 - tx end resets one, set disabled/empty last
// R10 - tx end cleared by armed zero, data write
// R11 - received address bit captured, held when off
// R12 - transmit address bit writable, resets zero
// R13 - divisor eight bits, resets to all ones
// R14 - async period (N+1)*64*2^(2n-1) clocks
// R15 - sync period (N+1)*8*2^(2n-1) clocks
// R16 - address wait discards zero-bit characters, but their parity errors still set the parity flag
// R17 - transmitter off holds empty and end set
// R18 - hardware set beats software clear
module ssbr_core #(
   parameter CNT_W = 20
) (
   input  wire        clock,
   input  wire        sys_rst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        txTake,
   input  wire        txLastBit,
   input  wire        rxDone,
   input  wire [7:0]  rxData,
   input  wire        rxMpBit,
   input  wire        rxParityErr,
   input  wire        rxFramingErr,
   output reg  [7:0]  txData,
   output wire        txMpBit,
   output wire        txOn,
   output wire        rxOn,
   output wire        syncMode,
   output reg         bitTick,
   output wire        irq
);

   reg  [7:0]       flags_reg;
   reg  [7:0]       flags_next;
   reg  [7:0]       armed_reg;
   reg  [7:0]       armed_next;
   reg  [7:0]       bit_rate_divisor;
   reg  [7:0]       rx_buffer;
   reg  [7:0]       control_reg;
   reg  [7:0]       mode_reg;
   reg  [3:0]       irqStat_reg;
   reg  [3:0]       irqStat_next;
   reg  [3:0]       irqMask_reg;
   reg  [CNT_W-1:0] rateCnt_reg;
   reg              mapped;
   reg  [7:0]       rdMux;

   wire setup    = psel & ~penable;
   wire access   = psel & penable;
   wire wrAcc    = access & pwrite;
   wire rdAcc    = access & ~pwrite;
   wire wrFlags  = wrAcc & (paddr == `SSBR_OFS_FLAGS);
   wire wrTxBuf  = wrAcc & (paddr == `SSBR_OFS_TXBUF);
   wire rdFlags  = rdAcc & (paddr == `SSBR_OFS_FLAGS);
   wire rdRxBuf  = rdAcc & (paddr == `SSBR_OFS_RXBUF);
   wire rdIrq    = rdAcc & (paddr == `SSBR_OFS_IRQSTAT);
   wire waitOn   = control_reg[`SSBR_WAIT_BIT];

   assign pready   = 1'b1;
   assign pslverr  = access & ~mapped;
   assign txOn     = control_reg[`SSBR_TXON_BIT];
   assign rxOn     = control_reg[`SSBR_RXON_BIT];
   assign syncMode = mode_reg[`SSBR_SYNC_BIT];
   assign txMpBit  = flags_reg[`SSBR_TX_ADDR_FLAG_BIT_BIT];
   assign irq      = |(irqStat_reg & irqMask_reg);

   // period in clocks: (N+1) * base/2 * 4^n, base 64 async or 8 sync
   function [CNT_W-1:0] bitPeriod;
      input [7:0] n;
      input [1:0] pre;
      input       sync;
      reg   [CNT_W-1:0] base;
      begin
         base = sync ? `SSBR_SYNC_BASE : `SSBR_ASYNC_BASE;
         bitPeriod = (({{(CNT_W-8){1'b0}}, n} + 1'b1) * base) << {pre, 1'b0};
      end
   endfunction

   // sw clear: a zero written to a flag that was last read as one
   function swClear;
      input       wr;
      input [7:0] data;
      input [7:0] armed;
      input integer b;
      begin
         swClear = wr & ~data[b] & armed[b];
      end
   endfunction

   always @* begin
      mapped = 1'b1;
      rdMux  = 8'h00;
      case (paddr)
         `SSBR_OFS_FLAGS:   rdMux = flags_reg;
         `SSBR_OFS_DIVISOR: rdMux = bit_rate_divisor;
         `SSBR_OFS_TXBUF:   rdMux = txData;
         `SSBR_OFS_RXBUF:   rdMux = rx_buffer;
         `SSBR_OFS_CONTROL: rdMux = control_reg;
         `SSBR_OFS_MODE:    rdMux = mode_reg;
         `SSBR_OFS_IRQSTAT: rdMux = {4'h0, irqStat_reg};
         `SSBR_OFS_IRQMASK: rdMux = {4'h0, irqMask_reg};
         default:           mapped = 1'b0;
      endcase
   end

   // read data captured in setup so it is stable through the access phase
   always @(posedge clock) begin
      if (sys_rst) begin
         prdata <= 32'h00000000;
      end else if (setup & ~pwrite) begin
         prdata <= {24'h000000, rdMux};
      end
   end

   // receive event decode
   wire rxTaken  = rxDone & rxOn;
   wire rxSkip   = waitOn & ~rxMpBit;                                 // [R16]
   wire rxOvr    = rxTaken & ~rxSkip & flags_reg[`SSBR_RX_BUFFER_FULL_BIT];
   wire rxFrm    = rxTaken & ~rxSkip & rxFramingErr;
   wire rxPar    = rxTaken & rxParityErr;
   wire rxGood   = rxTaken & ~rxSkip & ~rxOvr & ~rxFramingErr & ~rxParityErr;
   wire txeSet   = ~txOn | txTake;                                    // [R2] [R17]
   wire tendSet  = ~txOn | (txLastBit & flags_reg[`SSBR_TX_BUFFER_EMPTY_BIT]);   // [R9] [R17]

   always @* begin
      flags_next = flags_reg;
      armed_next = armed_reg;
      // arming uses the value software actually saw
      if (rdFlags) begin
         armed_next = armed_reg | prdata[7:0];
      end
      if (wrFlags) begin
         armed_next = 8'h00;
         flags_next[`SSBR_TX_ADDR_FLAG_BIT_BIT] = pwdata[`SSBR_TX_ADDR_FLAG_BIT_BIT];        // [R12]
      end
      // writes of one are ignored except to the tx address bit: only clears are applied
      if (swClear(wrFlags, pwdata[7:0], armed_reg, `SSBR_TX_BUFFER_EMPTY_BIT) | wrTxBuf) begin
         flags_next[`SSBR_TX_BUFFER_EMPTY_BIT] = 1'b0;                           // [R1] [R3]
      end
      if (swClear(wrFlags, pwdata[7:0], armed_reg, `SSBR_RX_BUFFER_FULL_BIT) | rdRxBuf) begin
         flags_next[`SSBR_RX_BUFFER_FULL_BIT] = 1'b0;                           // [R1] [R5]
      end
      if (swClear(wrFlags, pwdata[7:0], armed_reg, `SSBR_OVR_BIT)) begin
         flags_next[`SSBR_OVR_BIT] = 1'b0;                            // [R1] [R6]
      end
      if (swClear(wrFlags, pwdata[7:0], armed_reg, `SSBR_FRM_BIT)) begin
         flags_next[`SSBR_FRM_BIT] = 1'b0;                            // [R1] [R7]
      end
      if (swClear(wrFlags, pwdata[7:0], armed_reg, `SSBR_PAR_BIT)) begin
         flags_next[`SSBR_PAR_BIT] = 1'b0;                            // [R1] [R8]
      end
      if (swClear(wrFlags, pwdata[7:0], armed_reg, `SSBR_TRANSMIT_END_FLAG_BIT) | wrTxBuf) begin
         flags_next[`SSBR_TRANSMIT_END_FLAG_BIT] = 1'b0;                           // [R10]
      end
      // hardware sets come last so they win in the same cycle
      if (txeSet) begin
         flags_next[`SSBR_TX_BUFFER_EMPTY_BIT] = 1'b1;                           // [R2] [R18]
      end
      if (rxGood) begin
         flags_next[`SSBR_RX_BUFFER_FULL_BIT] = 1'b1;                           // [R4] [R18]
      end
      if (rxOvr) begin
         flags_next[`SSBR_OVR_BIT] = 1'b1;                            // [R6] [R18]
      end
      if (rxFrm) begin
         flags_next[`SSBR_FRM_BIT] = 1'b1;                            // [R7] [R18]
      end
      if (rxPar) begin
         flags_next[`SSBR_PAR_BIT] = 1'b1;                            // [R8] [R18]
      end
      if (tendSet) begin
         flags_next[`SSBR_TRANSMIT_END_FLAG_BIT] = 1'b1;                           // [R9] [R18]
      end
      // holds while reception is off since rxTaken needs rxOn
      if (rxTaken) begin
         flags_next[`SSBR_RX_ADDR_FLAG_BIT_BIT] = rxMpBit;                        // [R11]
      end
   end

   always @* begin
      irqStat_next = rdIrq ? (irqStat_reg & ~prdata[3:0]) : irqStat_reg;
      if (txTake) begin
         irqStat_next[`SSBR_IRQ_TXE_BIT] = 1'b1;
      end
      if (rxGood) begin
         irqStat_next[`SSBR_IRQ_RXF_BIT] = 1'b1;
      end
      if (rxOvr | rxFrm | rxPar) begin
         irqStat_next[`SSBR_IRQ_ERR_BIT] = 1'b1;
      end
      if (txLastBit & flags_reg[`SSBR_TX_BUFFER_EMPTY_BIT]) begin
         irqStat_next[`SSBR_IRQ_TRANSMIT_END_FLAG_BIT] = 1'b1;
      end
   end

   always @(posedge clock) begin
      if (sys_rst) begin
         flags_reg   <= `SSBR_FLAGS_RESET;                            // [R2] [R9]
         armed_reg   <= 8'h00;
         irqStat_reg <= 4'h0;
      end else begin
         flags_reg   <= flags_next;
         armed_reg   <= armed_next;
         irqStat_reg <= irqStat_next;
      end
   end

   always @(posedge clock) begin
      if (sys_rst) begin
         bit_rate_divisor <= `SSBR_DIVISOR_RESET;                     // [R13]
         control_reg      <= 8'h00;
         mode_reg         <= 8'h00;
         irqMask_reg      <= 4'h0;
         txData           <= 8'h00;
      end else begin
         if (wrAcc) begin
            case (paddr)
               `SSBR_OFS_DIVISOR: bit_rate_divisor <= pwdata[7:0];    // [R13]
               `SSBR_OFS_TXBUF:   txData <= pwdata[7:0];
               `SSBR_OFS_CONTROL: control_reg <= pwdata[7:0];
               `SSBR_OFS_MODE:    mode_reg <= pwdata[7:0];
               `SSBR_OFS_IRQMASK: irqMask_reg <= pwdata[3:0];
               default: ;
            endcase
         end
         // an unrelated register write must not swallow the wait release
         if (rxTaken & waitOn & rxMpBit & ~(wrAcc & (paddr == `SSBR_OFS_CONTROL))) begin
            control_reg[`SSBR_WAIT_BIT] <= 1'b0;                      // [R16]
         end
      end
   end

   // overrun keeps the unread byte, errored characters are not stored
   always @(posedge clock) begin
      if (sys_rst) begin
         rx_buffer <= 8'h00;
      end else if (rxGood) begin
         rx_buffer <= rxData;                                         // [R4]
      end
   end

   // restart on any divisor or mode write so the new rate takes at once
   wire rateReload = wrAcc & ((paddr == `SSBR_OFS_DIVISOR) | (paddr == `SSBR_OFS_MODE));

   always @(posedge clock) begin
      if (sys_rst) begin
         rateCnt_reg <= {CNT_W{1'b0}};
         bitTick     <= 1'b0;
      end else if (rateReload) begin
         rateCnt_reg <= {CNT_W{1'b0}};
         bitTick     <= 1'b0;
      end else if (rateCnt_reg == bitPeriod(bit_rate_divisor, mode_reg[1:0], syncMode) - 1'b1) begin
         rateCnt_reg <= {CNT_W{1'b0}};                                // [R14] [R15]
         bitTick     <= 1'b1;
      end else begin
         rateCnt_reg <= rateCnt_reg + 1'b1;
         bitTick     <= 1'b0;
      end
   end

endmodule // ssbr_core

// [verif/ssbr_asserts.sv]
// port assertions for the serial status block
`timescale 1ns/1ps
module ssbr_checker #(
   parameter CNT_W = 20
) (
   input wire        clock,
   input wire        sys_rst,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        txTake,
   input wire        rxDone,
   input wire        rxMpBit,
   input wire        rxParityErr,
   input wire        rxFramingErr,
   input wire [7:0]  txData,
   input wire        txMpBit,
   input wire        txOn,
   input wire        rxOn,
   input wire        syncMode,
   input wire        bitTick
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   wire             acc = psel && penable;
   wire             rdFlags = psel && !penable && !pwrite && paddr == 8'h00;
   wire             rateWr = acc && pwrite && (paddr == 8'h04 || paddr == 8'h14);
   reg  [7:0]       nDiv;
   reg  [1:0]       pre;
   reg  [CNT_W-1:0] gap;
   reg              seen;
   wire [31:0]      parity_error_flag = ((nDiv + 32'h1) * (syncMode ? 32'h4 : 32'h20)) << (2 * pre);
   // only tick-to-tick gaps are judged: restart phase after a rate write is the design's choice
   always @(posedge clock) begin
      if (sys_rst) begin
         nDiv <= 8'hFF;
         pre <= 2'h0;
         gap <= '0;
         seen <= 1'b0;
      end else begin
         if (rateWr && paddr == 8'h04)
            nDiv <= pwdata[7:0];
         if (rateWr && paddr == 8'h14)
            pre <= pwdata[1:0];
         gap <= (bitTick || rateWr) ? '0 : gap + 1'b1;
         seen <= rateWr ? 1'b0 : (seen || bitTick);
      end
   end
   access_ready_a: assert property (acc |-> pready) else $error("no ready in access");
   unmapped_refused_a: assert property (acc && !pwrite && paddr > 8'h1C |-> pslverr && prdata == 32'h0)
      else $error("unmapped read not refused");
   txoff_flags_a: assert property (rdFlags && !txOn && $past(!txOn) |=> prdata[7] && prdata[2])
      else $error("empty or end flag low while tx off");
   rx_full_set_a: assert property (rxDone && rxOn && rxMpBit && !rxParityErr && !rxFramingErr ##2 rdFlags
      |=> prdata[6] && prdata[1]) else $error("clean receive not flagged");
   tx_write_clear_a: assert property (acc && pwrite && paddr == 8'h08 && txOn && !txTake ##1 txOn && !txTake
      ##1 rdFlags && !txTake |=> !prdata[7] && !prdata[2]) else $error("buffer write did not clear flags");
   tx_data_load_a: assert property (acc && pwrite && paddr == 8'h08
      |=> {24'h0, txData} == ($past(pwdata) & 32'h0000_00FF)) else $error("tx buffer not loaded");
   tx_addr_bit_a: assert property (acc && pwrite && paddr == 8'h00
      |=> {31'h0, txMpBit} == ($past(pwdata) & 32'h1)) else $error("tx address bit not written");
   tick_period_a: assert property (bitTick && seen |-> gap == parity_error_flag[CNT_W-1:0] - 1'b1)
      else $error("bit period wrong");
endmodule // ssbr_checker

// [verif/ssbr_engine_model.sv]
// behavioural shift engine giving the block its event pulses
`timescale 1ns/1ps
module ssbr_engine_model (
   input wire       clock,
   output reg       txTake,
   output reg       txLastBit,
   output reg       rxDone,
   output reg [7:0] rxData,
   output reg       rxMpBit,
   output reg       rxParityErr,
   output reg       rxFramingErr
);
   initial begin
      {txTake, txLastBit, rxDone, rxData, rxMpBit, rxParityErr, rxFramingErr} = 14'h0000;
   end
   // fields are inverted after the pulse so stale values never look valid
   task recv(input [7:0] d, input mp, input pe, input fe);
      begin
         rxData <= d;
         rxMpBit <= mp;
         rxParityErr <= pe;
         rxFramingErr <= fe;
         rxDone <= 1'b1;
         @(posedge clock);
         rxDone <= 1'b0;
         rxData <= ~d;
         rxMpBit <= ~mp;
         rxParityErr <= ~pe;
         rxFramingErr <= ~fe;
         @(posedge clock);
      end
   endtask
   task pulse_tx(input last);
      begin
         txTake <= !last;
         txLastBit <= last;
         @(posedge clock);
         txTake <= 1'b0;
         txLastBit <= 1'b0;
         @(posedge clock);
      end
   endtask
endmodule // ssbr_engine_model

// [verif/test_serial_status_and_bit_rate.sv]
// self-checking bench for the serial status and bit-rate block
`timescale 1ns/1ps
module test_serial_status_and_bit_rate;
   reg         clock = 1'b0;
   reg         sys_rst = 1'b1;
   reg         psel = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite = 1'b0;
   reg  [7:0]  paddr = 8'h00;
   reg  [31:0] pwdata = 32'h0;
   reg  [31:0] rdVal;
   wire [31:0] prdata;
   wire [7:0]  rxData, txData;
   wire        pready, pslverr, txTake, txLastBit, rxDone, rxMpBit, rxParityErr, rxFramingErr;
   wire        txMpBit, txOn, rxOn, syncMode, bitTick, irq;
   integer     num_errors = 0;
   integer     n_compared = 0;
   always #5 clock = ~clock;
   ssbr_core #(.CNT_W(20)) dut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .txTake(txTake),
      .txLastBit(txLastBit), .rxDone(rxDone), .rxData(rxData), .rxMpBit(rxMpBit), .rxParityErr(rxParityErr),
      .rxFramingErr(rxFramingErr), .txData(txData), .txMpBit(txMpBit), .txOn(txOn), .rxOn(rxOn),
      .syncMode(syncMode), .bitTick(bitTick), .irq(irq));
   ssbr_engine_model eng (.clock(clock), .txTake(txTake), .txLastBit(txLastBit), .rxDone(rxDone), .rxData(rxData),
      .rxMpBit(rxMpBit), .rxParityErr(rxParityErr), .rxFramingErr(rxFramingErr));
   task finish_test;
      begin
         if (num_errors == 0 && n_compared > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   task chk(input string name, input [31:0] e, input [31:0] g);
      begin
         n_compared = n_compared + 1;
         if (g !== e) begin
            $display("[ERR] %s exp %h got %h", name, e, g);
            num_errors = num_errors + 1;
         end
      end
   endtask
   // one transfer; leaves an idle cycle so strobes are never reassigned in one step
   task apb(input w, input [7:0] a, input [31:0] d);
      integer i;
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clock);
         penable <= 1'b1;
         @(posedge clock);
         for (i = 0; i < 16 && pready !== 1'b1; i = i + 1)
            @(posedge clock);
         rdVal = prdata;
         if (i == 16) begin
            num_errors = num_errors + 1;
            finish_test;
         end
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge clock);
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input [7:0] a, input [31:0] e);
      begin
         apb(1'b0, a, 32'h0);
         chk($sformatf("reg %h", a), e, rdVal);
      end
   endtask
   initial begin
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      rd(8'h00, 32'h84);
      rd(8'h04, 32'hFF);
      rd(8'h20, 32'h0);
      wr(8'h00, 32'hFF);
      rd(8'h00, 32'h85);
      wr(8'h10, 32'h30);
      wr(8'h04, 32'h01);
      rd(8'h04, 32'h01);
      wr(8'h14, 32'h00);
      repeat (200) @(posedge clock);
      wr(8'h14, 32'h81);
      repeat (100) @(posedge clock);
      wr(8'h08, 32'h5A);
      rd(8'h00, 32'h01);
      eng.pulse_tx(1'b0);
      rd(8'h00, 32'h81);
      eng.pulse_tx(1'b1);
      rd(8'h00, 32'h85);
      wr(8'h00, 32'h01);
      rd(8'h00, 32'h01);
      wr(8'h10, 32'h10);
      rd(8'h00, 32'h85);
      eng.recv(8'hA5, 1'b1, 1'b0, 1'b0);
      rd(8'h00, 32'hC7);
      rd(8'h0C, 32'hA5);
      rd(8'h00, 32'h87);
      eng.recv(8'h11, 1'b0, 1'b0, 1'b0);
      eng.recv(8'h22, 1'b0, 1'b0, 1'b0);
      rd(8'h00, 32'hE5);
      rd(8'h0C, 32'h11);
      rd(8'h00, 32'hA5);
      wr(8'h00, 32'h85);
      rd(8'h00, 32'h85);
      eng.recv(8'h33, 1'b0, 1'b1, 1'b0);
      eng.recv(8'h44, 1'b0, 1'b0, 1'b1);
      rd(8'h00, 32'h9D);
      wr(8'h00, 32'h81);
      rd(8'h00, 32'h85);
      wr(8'h1C, 32'h04);
      chk("irq", 32'h1, {31'h0, irq});
      wr(8'h1C, 32'h00);
      chk("irq", 32'h0, {31'h0, irq});
      wr(8'h1C, 32'h04);
      apb(1'b0, 8'h18, 32'h0);
      chk("irq status", 32'h4, rdVal & 32'h4);
      chk("irq", 32'h0, {31'h0, irq});
      wr(8'h10, 32'h18);
      eng.recv(8'h55, 1'b0, 1'b0, 1'b0);
      rd(8'h00, 32'h85);
      eng.recv(8'h66, 1'b1, 1'b0, 1'b0);
      rd(8'h00, 32'hC7);
      rd(8'h10, 32'h10);
      rd(8'h0C, 32'h66);
      wr(8'h10, 32'h00);
      eng.recv(8'h77, 1'b0, 1'b0, 1'b0);
      rd(8'h00, 32'h87);
      finish_test;
   end
endmodule // test_serial_status_and_bit_rate
bind ssbr_core ssbr_checker #(.CNT_W(CNT_W)) watch (.clock(clock), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .txTake(txTake), .rxDone(rxDone), .rxMpBit(rxMpBit), .rxParityErr(rxParityErr),
   .rxFramingErr(rxFramingErr), .txData(txData), .txMpBit(txMpBit), .txOn(txOn), .rxOn(rxOn),
   .syncMode(syncMode), .bitTick(bitTick));
